// ---- design/arf_regs.vh ----
// Operation
// - frequency-correction code is 13 bits: low register 10 lsbs, high register 3 msbs
// - upper correction bits pass through a shadow stage when the low register is written
// - correction power gated by power-down-pin permit bit and active bit
// - control two bit selects correction output resistance and swing
// - 10-bit receive-gain converter driven from a host-writable gain register
// - receive-gain power gated by window-enable bit and active bit
// - control two bit selects receive-gain output swing
// - power level drives 8-bit level converter, referenced by 5-bit shape converter
// - ramp-up steps shape memory 0 to 62, ramp-down 63 down to 1
// - shape addresses step at 4 MHz with speed bit 0, 2 MHz with 1
// - ramp-up uses low five bits of each word, ramp-down the upper bits
// - ramp start delayed from burst enable by 4-bit count of quarter-bits
// - power output forced to zero when powered down, level zero or no ramp
// - offset mode 0 scales level plus offset; mode 1 adds offset after product
// - power-control power gated by window-enable bit and active bit
// - control two bit selects power-control output swing
// - three-bit field in control one selects one of five monitor inputs
// - monitor power gated by power-down-pin permit bit and active bit
// - any write to control one starts a monitor conversion
// - busy flag is 1 during conversion, cleared when result is loaded
// - active bit 0 powers down; window-enable 0 lets inactive window power down
// - burst enable while uplink window is active starts the burst
// - modulation runs 32 quarter-bits after burst enable falls; ramp-down starts after the ramp delay count
`ifndef ARF_REGS_VH
`define ARF_REGS_VH

// register byte offsets
`define ARF_FREQ_CORR_LOW 12'h000
`define ARF_FREQ_CORR_HIGH 12'h004
`define ARF_AUX_CONTROL_ONE 12'h008
`define ARF_AUX_CONTROL_TWO 12'h00c
`define ARF_RX_GAIN_VALUE 12'h010
`define ARF_TX_POWER_LEVEL 12'h014
`define ARF_RAMP_DELAY 12'h018
`define ARF_POWER_OFFSET 12'h01c
`define ARF_BASEBAND_STATUS 12'h020
`define ARF_MONITOR_RESULT 12'h024
`define ARF_RAMP_MEM_BASE 12'h100
`define ARF_RAMP_MEM_LAST 12'h1fc

// aux_control_one fields
`define ARF_C1_CHAN_LSB 0
`define ARF_C1_FC_PIN_PD_EN 3
`define ARF_C1_FC_ACTIVE 4
`define ARF_C1_MON_PIN_PD_EN 5
`define ARF_C1_MON_ACTIVE 6

// aux_control_two fields
`define ARF_C2_FC_SWING 0
`define ARF_C2_RG_WIN_EN 1
`define ARF_C2_RG_ACTIVE 2
`define ARF_C2_RG_SWING 3
`define ARF_C2_TP_WIN_EN 4
`define ARF_C2_TP_ACTIVE 5
`define ARF_C2_TP_SWING 6
`define ARF_C2_RAMP_SPEED 7
`define ARF_C2_OFFSET_MODE 8

// status fields
`define ARF_ST_MON_BUSY 0
`define ARF_ST_RAMP_RUN 1
`define ARF_ST_MODULATING 2

// reset values
`define ARF_C1_RESET 7'h00
`define ARF_C2_RESET 9'h000
`define ARF_OFFSET_RESET 8'h00

// timing
`define ARF_CLK_PS 10000
`define ARF_STEP_FAST_PS 250000
`define ARF_STEP_SLOW_PS 500000
`define ARF_QBIT_PS 923077
`define ARF_TAIL_QBITS 6'h20
`define ARF_UP_LAST 6'h3e
`define ARF_DOWN_FIRST 6'h3f
`define ARF_DOWN_LAST 6'h01

`endif

// ---- design/arf_ctrl.v ----
`timescale 1ns/1ps
`include "arf_regs.vh"

module arf_ctrl #(
    parameter FC_LOW_W = 10,
    parameter FC_HIGH_W = 3,
    parameter RG_W = 10,
    parameter LEVEL_W = 8,
    parameter SHAPE_W = 5,
    parameter MON_W = 10,
    parameter RAMP_DEPTH = 64
) (
    input wire pclk, // bus and logic clock, 100 MHz
    input wire presetn, // asynchronous reset, active low
    input wire psel, // apb select
    input wire penable, // apb access phase
    input wire pwrite, // apb direction, 1 = write
    input wire [11:0] paddr, // apb byte address
    input wire [31:0] pwdata, // apb write data
    output wire [31:0] prdata, // apb read data
    output wire pready, // apb ready
    output wire pslverr, // apb error on unmapped address
    input wire power_down_pin, // external power-down pin, high = power down
    input wire uplink_window, // transmit window
    input wire downlink_window, // receive window
    input wire burst_enable, // burst enable from the timing interface
    output reg [FC_LOW_W+FC_HIGH_W-1:0] freq_corr_code, // correction converter code
    output wire freq_corr_pd, // correction converter power-down
    output wire freq_corr_swing_sel, // correction resistance and swing
    output wire [RG_W-1:0] rx_gain_code, // receive-gain converter code
    output wire rx_gain_pd, // receive-gain converter power-down
    output wire rx_gain_swing_sel, // receive-gain swing
    output reg [LEVEL_W-1:0] tx_level_code, // level converter code
    output reg [SHAPE_W-1:0] tx_shape_code, // shape converter code
    output reg [SHAPE_W+LEVEL_W:0] tx_power_drive, // combined power-control value
    output wire tx_power_pd, // power-control power-down
    output wire tx_power_swing_sel, // power-control swing
    output wire modulating, // modulation in progress
    output wire [2:0] monitor_channel_sel, // monitor input select
    output wire monitor_pd, // monitor converter power-down
    output reg monitor_conv_start, // one-cycle conversion start pulse
    input wire monitor_conv_done, // converter result valid, one cycle
    input wire [MON_W-1:0] monitor_conv_data // converter result
);

    // ==========================================================
    // timing constants
    // ==========================================================
    localparam integer STEP_FAST = `ARF_STEP_FAST_PS / `ARF_CLK_PS;
    localparam integer STEP_SLOW = `ARF_STEP_SLOW_PS / `ARF_CLK_PS;
    localparam integer QBIT_CYC = `ARF_QBIT_PS / `ARF_CLK_PS;

    localparam [2:0] ST_IDLE = 3'h0;
    localparam [2:0] ST_UP_DELAY = 3'h1;
    localparam [2:0] ST_UP = 3'h2;
    localparam [2:0] ST_HOLD = 3'h3;
    localparam [2:0] ST_DOWN_DELAY = 3'h4;
    localparam [2:0] ST_DOWN = 3'h5;

    // ==========================================================
    // registers
    // ==========================================================
    reg [FC_LOW_W-1:0] freq_corr_low;
    reg [FC_HIGH_W-1:0] freq_corr_high;
    reg [6:0] aux_control_one;
    reg [8:0] aux_control_two;
    reg [RG_W-1:0] rx_gain_value;
    reg [LEVEL_W-1:0] tx_power_level;
    reg [3:0] ramp_delay;
    reg [LEVEL_W-1:0] power_offset;
    reg [MON_W-1:0] monitor_result;
    reg monitor_conv_busy;
    reg [SHAPE_W*2-1:0] ramp_shape_memory [0:RAMP_DEPTH-1];

    reg ack;
    reg [31:0] rdata;
    reg err;
    reg [31:0] next_rdata;
    reg next_err;

    reg [2:0] state;
    reg [5:0] ramp_addr;
    reg [7:0] step_cnt;
    reg [7:0] qbit_cnt;
    reg [3:0] delay_cnt;
    reg [5:0] tail_cnt;
    reg burst_q;

    wire wr_en;
    wire burst_start;
    wire burst_end;
    wire step_tick;
    wire qbit_tick;
    wire mem_sel;
    wire [SHAPE_W*2-1:0] mem_word;
    wire [SHAPE_W-1:0] shape_now;
    wire [SHAPE_W+LEVEL_W:0] drive_now;

    // address decode shared by read and write paths
    function is_mem;
        input [11:0] a;
        begin
            is_mem = (a >= `ARF_RAMP_MEM_BASE) && (a <= `ARF_RAMP_MEM_LAST);
        end
    endfunction

    // ==========================================================
    // apb slave: setup, one wait cycle, then ready
    // ==========================================================
    assign pready = ack;
    assign prdata = rdata;
    assign pslverr = err;
    assign wr_en = psel & penable & ack & pwrite;
    assign mem_sel = is_mem(paddr);

    // read mux, evaluated in the first access cycle
    always @* begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        if (mem_sel) begin
            next_rdata[SHAPE_W*2-1:0] = ramp_shape_memory[paddr[7:2]];
        end else begin
            case (paddr)
                `ARF_FREQ_CORR_LOW: next_rdata[FC_LOW_W-1:0] = freq_corr_low;
                `ARF_FREQ_CORR_HIGH: next_rdata[FC_HIGH_W-1:0] = freq_corr_high;
                `ARF_AUX_CONTROL_ONE: next_rdata[6:0] = aux_control_one;
                `ARF_AUX_CONTROL_TWO: next_rdata[8:0] = aux_control_two;
                `ARF_RX_GAIN_VALUE: next_rdata[RG_W-1:0] = rx_gain_value;
                `ARF_TX_POWER_LEVEL: next_rdata[LEVEL_W-1:0] = tx_power_level;
                `ARF_RAMP_DELAY: next_rdata[3:0] = ramp_delay;
                `ARF_POWER_OFFSET: next_rdata[LEVEL_W-1:0] = power_offset;
                `ARF_BASEBAND_STATUS: begin
                    next_rdata[`ARF_ST_MON_BUSY] = monitor_conv_busy;
                    next_rdata[`ARF_ST_RAMP_RUN] = (state != ST_IDLE);
                    next_rdata[`ARF_ST_MODULATING] = modulating;
                end
                `ARF_MONITOR_RESULT: next_rdata[MON_W-1:0] = monitor_result;
                default: next_err = 1'b1;
            endcase
        end
    end

    // handshake and registered read data
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
            err <= 1'b0;
        end else begin
            ack <= psel & penable & ~ack;
            if (psel & penable & ~ack) begin
                rdata <= pwrite ? 32'h0000_0000 : next_rdata;
                err <= next_err;
            end else if (ack) begin
                err <= 1'b0;
            end
        end
    end

    // ==========================================================
    // software-written registers
    // ==========================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            freq_corr_low <= {FC_LOW_W{1'b0}};
            freq_corr_high <= {FC_HIGH_W{1'b0}};
            freq_corr_code <= {(FC_LOW_W+FC_HIGH_W){1'b0}};
            aux_control_one <= `ARF_C1_RESET;
            aux_control_two <= `ARF_C2_RESET;
            rx_gain_value <= {RG_W{1'b0}};
            tx_power_level <= {LEVEL_W{1'b0}};
            ramp_delay <= 4'h0;
            power_offset <= `ARF_OFFSET_RESET;
        end else if (wr_en) begin
            case (paddr)
                `ARF_FREQ_CORR_LOW: begin
                    freq_corr_low <= pwdata[FC_LOW_W-1:0];
                    // shadowed msbs move together with the new lsbs
                    freq_corr_code <= {freq_corr_high, pwdata[FC_LOW_W-1:0]};
                end
                `ARF_FREQ_CORR_HIGH: freq_corr_high <= pwdata[FC_HIGH_W-1:0];
                `ARF_AUX_CONTROL_ONE: aux_control_one <= pwdata[6:0];
                `ARF_AUX_CONTROL_TWO: aux_control_two <= pwdata[8:0];
                `ARF_RX_GAIN_VALUE: rx_gain_value <= pwdata[RG_W-1:0];
                `ARF_TX_POWER_LEVEL: tx_power_level <= pwdata[LEVEL_W-1:0];
                `ARF_RAMP_DELAY: ramp_delay <= pwdata[3:0];
                `ARF_POWER_OFFSET: power_offset <= pwdata[LEVEL_W-1:0];
                default: ;
            endcase
        end
    end

    // shape memory, written word by word
    always @(posedge pclk) begin
        if (wr_en && mem_sel) begin
            ramp_shape_memory[paddr[7:2]] <= pwdata[SHAPE_W*2-1:0];
        end
    end

    // ==========================================================
    // power gating and static outputs
    // ==========================================================
    assign freq_corr_pd = ~aux_control_one[`ARF_C1_FC_ACTIVE]
        | (aux_control_one[`ARF_C1_FC_PIN_PD_EN] & power_down_pin);
    assign freq_corr_swing_sel = aux_control_two[`ARF_C2_FC_SWING];
    assign rx_gain_code = rx_gain_value;
    assign rx_gain_pd = ~aux_control_two[`ARF_C2_RG_ACTIVE]
        | (~aux_control_two[`ARF_C2_RG_WIN_EN] & ~downlink_window);
    assign rx_gain_swing_sel = aux_control_two[`ARF_C2_RG_SWING];
    assign tx_power_pd = ~aux_control_two[`ARF_C2_TP_ACTIVE]
        | (~aux_control_two[`ARF_C2_TP_WIN_EN] & ~uplink_window);
    assign tx_power_swing_sel = aux_control_two[`ARF_C2_TP_SWING];
    assign monitor_channel_sel = aux_control_one[`ARF_C1_CHAN_LSB+2:`ARF_C1_CHAN_LSB];
    assign monitor_pd = ~aux_control_one[`ARF_C1_MON_ACTIVE]
        | (aux_control_one[`ARF_C1_MON_PIN_PD_EN] & power_down_pin);

    // ==========================================================
    // monitor conversion control
    // ==========================================================
    // a fresh start wins over a completion landing in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            monitor_conv_start <= 1'b0;
            monitor_conv_busy <= 1'b0;
            monitor_result <= {MON_W{1'b0}};
        end else begin
            monitor_conv_start <= wr_en && (paddr == `ARF_AUX_CONTROL_ONE);
            if (monitor_conv_busy && monitor_conv_done) begin
                monitor_result <= monitor_conv_data;
            end
            if (monitor_conv_start) begin
                monitor_conv_busy <= 1'b1;
            end else if (monitor_conv_done) begin
                monitor_conv_busy <= 1'b0;
            end
        end
    end

    // ==========================================================
    // rate dividers: shape step and quarter-bit
    // ==========================================================
    assign step_tick = (step_cnt == 8'h00);
    assign qbit_tick = (qbit_cnt == 8'h00);

    // step rate follows the speed bit, quarter-bit runs free
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_cnt <= 8'h00;
            qbit_cnt <= 8'h00;
        end else begin
            if (step_tick || state == ST_IDLE) begin
                step_cnt <= aux_control_two[`ARF_C2_RAMP_SPEED] ?
                    STEP_SLOW[7:0] - 8'h01 : STEP_FAST[7:0] - 8'h01;
            end else begin
                step_cnt <= step_cnt - 8'h01;
            end
            if (qbit_tick) begin
                qbit_cnt <= QBIT_CYC[7:0] - 8'h01;
            end else begin
                qbit_cnt <= qbit_cnt - 8'h01;
            end
        end
    end

    // ==========================================================
    // burst edges and modulation tail
    // ==========================================================
    assign burst_start = burst_enable & ~burst_q & uplink_window;
    assign burst_end = ~burst_enable & burst_q;
    assign modulating = burst_q | (tail_cnt != 6'h00);

    // tail keeps modulation alive after burst enable drops
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_q <= 1'b0;
            tail_cnt <= 6'h00;
        end else begin
            burst_q <= burst_enable & (uplink_window | burst_q);
            if (burst_end) begin
                tail_cnt <= `ARF_TAIL_QBITS;
            end else if (qbit_tick && tail_cnt != 6'h00) begin
                tail_cnt <= tail_cnt - 6'h01;
            end
        end
    end

    // ==========================================================
    // ramp sequencer
    // ==========================================================
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
            ramp_addr <= 6'h00;
            delay_cnt <= 4'h0;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (burst_start) begin
                        delay_cnt <= ramp_delay;
                        ramp_addr <= 6'h00;
                        state <= ST_UP_DELAY;
                    end
                end
                ST_UP_DELAY: begin
                    if (burst_end) begin
                        delay_cnt <= ramp_delay;
                        state <= ST_DOWN_DELAY;
                    end else if (delay_cnt == 4'h0) begin
                        state <= ST_UP;
                    end else if (qbit_tick) begin
                        delay_cnt <= delay_cnt - 4'h1;
                    end
                end
                ST_UP: begin
                    if (burst_end) begin
                        delay_cnt <= ramp_delay;
                        state <= ST_DOWN_DELAY;
                    end else if (step_tick) begin
                        if (ramp_addr == `ARF_UP_LAST) begin
                            state <= ST_HOLD;
                        end else begin
                            ramp_addr <= ramp_addr + 6'h01;
                        end
                    end
                end
                ST_HOLD: begin
                    if (burst_end) begin
                        delay_cnt <= ramp_delay;
                        state <= ST_DOWN_DELAY;
                    end
                end
                ST_DOWN_DELAY: begin
                    if (delay_cnt == 4'h0) begin
                        ramp_addr <= `ARF_DOWN_FIRST;
                        state <= ST_DOWN;
                    end else if (qbit_tick) begin
                        delay_cnt <= delay_cnt - 4'h1;
                    end
                end
                ST_DOWN: begin
                    if (step_tick) begin
                        if (ramp_addr == `ARF_DOWN_LAST) begin
                            state <= ST_IDLE;
                        end else begin
                            ramp_addr <= ramp_addr - 6'h01;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // ==========================================================
    // shape and level output
    // ==========================================================
    assign mem_word = ramp_shape_memory[ramp_addr];
    assign shape_now = (state == ST_DOWN) ? mem_word[SHAPE_W*2-1:SHAPE_W]
        : mem_word[SHAPE_W-1:0];
    assign drive_now = aux_control_two[`ARF_C2_OFFSET_MODE] ?
        (shape_now * tx_power_level) + power_offset
        : shape_now * (tx_power_level + power_offset);

    // output forced low unless the ramp runs with power and nonzero level
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shape_code <= {SHAPE_W{1'b0}};
            tx_level_code <= {LEVEL_W{1'b0}};
            tx_power_drive <= {(SHAPE_W+LEVEL_W+1){1'b0}};
        end else if (tx_power_pd || tx_power_level == {LEVEL_W{1'b0}}
                     || state == ST_IDLE || state == ST_UP_DELAY
                     || state == ST_DOWN_DELAY) begin
            tx_shape_code <= {SHAPE_W{1'b0}};
            tx_level_code <= {LEVEL_W{1'b0}};
            tx_power_drive <= {(SHAPE_W+LEVEL_W+1){1'b0}};
        end else begin
            tx_shape_code <= shape_now;
            tx_level_code <= tx_power_level;
            tx_power_drive <= drive_now;
        end
    end

endmodule

// ---- tb/arf_adc_model.sv ----
`timescale 1ns/1ps
// ==========
// converter model: answers each start pulse after lat cycles
module arf_adc_model (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic start, // conversion start pulse
    input wire logic [2:0] chan, // selected input
    input wire logic [7:0] lat, // answer delay in cycles
    output logic done, // result valid, one cycle
    output logic [9:0] data // result, toggles when not valid
);
    integer cnt;
    // countdown, a restart reloads it
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 0;
            done <= 1'b0;
            data <= 10'h000;
        end else begin
            done <= (cnt == 1);
            data <= (cnt == 1) ? {chan, 7'h35} : ~data;
            if (start)
                cnt <= lat;
            else if (cnt > 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// ---- tb/arf_monitor.sv ----
`timescale 1ns/1ps
// ==========
// port checker
module arf_monitor (
    input wire logic pclk, // clock
    input wire logic presetn, // reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb address
    input wire logic pready, // apb ready
    input wire logic pslverr, // apb error
    input wire logic burst_enable, // burst
    input wire logic [12:0] freq_corr_code, // correction code
    input wire logic [9:0] rx_gain_code, // gain code
    input wire logic [7:0] tx_level_code, // level code
    input wire logic [13:0] tx_power_drive, // power drive
    input wire logic tx_power_pd, // power-control down
    input wire logic modulating, // modulation
    input wire logic monitor_conv_start // start pulse
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic c1_wr, lo_wr, g_wr;
    wire wr = psel & penable & pready & pwrite;
    // remember which register was written at the last edge
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_wr <= 1'b0;
            lo_wr <= 1'b0;
            g_wr <= 1'b0;
        end else begin
            c1_wr <= wr && paddr == 12'h008;
            lo_wr <= wr && paddr == 12'h000;
            g_wr <= wr && paddr == 12'h010;
        end
    end
    chk_ready_one: assert property (pready |=> !pready)
        else $error("ready held too long");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    chk_start_cause: assert property (monitor_conv_start == c1_wr)
        else $error("start pulse not tied to control one write");
    chk_fc_update: assert property (!$stable(freq_corr_code) |-> lo_wr)
        else $error("correction code moved without low write");
    chk_gain_update: assert property (!$stable(rx_gain_code) |-> g_wr)
        else $error("gain code moved without write");
    chk_pd_zero: assert property (tx_power_pd |=> tx_power_drive == 14'h0000)
        else $error("drive not zero while powered down");
    chk_level_zero: assert property (tx_level_code == 8'h00 |-> tx_power_drive == 14'h0000)
        else $error("drive not zero at level zero");
    chk_tail_runs: assert property ($fell(burst_enable) && modulating |=> modulating [*8])
        else $error("modulation tail cut short");
    chk_mod_held: assert property ($fell(modulating) |-> !burst_enable)
        else $error("modulation ended during burst");
endmodule
bind arf_ctrl arf_monitor i_arf_monitor (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pready(pready), .pslverr(pslverr),
    .burst_enable(burst_enable), .freq_corr_code(freq_corr_code), .rx_gain_code(rx_gain_code),
    .tx_level_code(tx_level_code), .tx_power_drive(tx_power_drive),
    .tx_power_pd(tx_power_pd), .modulating(modulating),
    .monitor_conv_start(monitor_conv_start));

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
`include "arf_regs.vh"
// ==========
// bench for the auxiliary converter control
module tb_top;
    reg pclk, presetn, psel, penable, pwrite, pdp, ulw, dlw, ben, er;
    reg [11:0] paddr;
    reg [31:0] pwdata, rd, lvl, ofs, hi, lo, ev;
    reg [7:0] lat;
    wire [31:0] prdata;
    wire pready, pslverr, fpd, fsw, gpd, gsw, tpd, tsw, modl, mpd, st, dn;
    wire [12:0] fcc;
    wire [9:0] gc, md;
    wire [7:0] lvc;
    wire [4:0] shc;
    wire [13:0] drv;
    wire [2:0] ch;
    integer err_total, cmp_count, seed, cyc, k, n;
    arf_ctrl i_arf_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .power_down_pin(pdp), .uplink_window(ulw), .downlink_window(dlw),
        .burst_enable(ben), .freq_corr_code(fcc), .freq_corr_pd(fpd),
        .freq_corr_swing_sel(fsw), .rx_gain_code(gc), .rx_gain_pd(gpd),
        .rx_gain_swing_sel(gsw), .tx_level_code(lvc), .tx_shape_code(shc),
        .tx_power_drive(drv), .tx_power_pd(tpd), .tx_power_swing_sel(tsw), .modulating(modl),
        .monitor_channel_sel(ch), .monitor_pd(mpd), .monitor_conv_start(st),
        .monitor_conv_done(dn), .monitor_conv_data(md));
    arf_adc_model i_arf_adc_model (.pclk(pclk), .presetn(presetn), .start(st), .chan(ch),
        .lat(lat), .done(dn), .data(md));
    // clock and hang guard
    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total = err_total + 1;
            results;
        end
    end
    task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] want);
        begin
            cmp_count = cmp_count + 1;
            if (seen !== want) begin
                err_total = err_total + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, want, seen);
            end
        end
    endtask
    // one apb transfer, entered just after an edge, leaves one idle edge
    task apb(input w, input [11:0] a, input [31:0] d);
        begin
            psel <= 1'b1;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge pclk);
            penable <= 1'b1;
            do @(posedge pclk); while (pready !== 1'b1);
            rd = prdata;
            er = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task results;
        begin
            $display("compares %0d mismatches %0d", cmp_count, err_total);
            if (err_total == 0 && cmp_count > 0)
                $display("SIMULATION PASSED");
            else
                $display("SIMULATION FAILED");
            $finish;
        end
    endtask
    // ==========
    // main sequence
    initial begin
        err_total = 0;
        cmp_count = 0;
        seed = 70;
        cyc = 0;
        {presetn, psel, penable, pwrite, pdp, ulw, dlw, ben} = 8'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        lat = 8'd3;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(0, `ARF_AUX_CONTROL_TWO, 0);
        chk("ctl_two", rd, 0);
        chk("pd_rst", {fpd, gpd, tpd, mpd}, 4'hf);
        hi = $random(seed) & 32'h7;
        lo = $random(seed) & 32'h3ff;
        apb(1, `ARF_FREQ_CORR_HIGH, hi);
        chk("fc_hold", fcc, 0);
        apb(1, `ARF_FREQ_CORR_LOW, lo);
        chk("fc_code", fcc, {hi[2:0], lo[9:0]});
        for (k = 0; k < 8; k = k + 1) begin
            pdp <= k[2];
            apb(1, `ARF_AUX_CONTROL_ONE, {k[1], k[0], k[1], k[0], 3'(k % 5)});
            ev = !k[1] | (k[0] & k[2]);
            chk("fc_pd", fpd, ev);
            chk("mon_pd", mpd, ev);
            chk("chan", ch, k % 5);
        end
        for (k = 0; k < 16; k = k + 1) begin
            ulw <= k[2];
            dlw <= k[2];
            apb(1, `ARF_AUX_CONTROL_TWO, {2'b00, k[3], k[1], k[0], k[3], k[1], k[0], k[3]});
            ev = !k[1] | (!k[0] & !k[2]);
            chk("rg_pd", gpd, ev);
            chk("tp_pd", tpd, ev);
            chk("swing", {fsw, gsw, tsw}, {3{k[3]}});
        end
        lo = $random(seed) & 32'h3ff;
        apb(1, `ARF_RX_GAIN_VALUE, lo);
        chk("gain", gc, lo);
        lat <= 8'd40;
        apb(1, `ARF_AUX_CONTROL_ONE, 7'h52);
        apb(0, `ARF_BASEBAND_STATUS, 0);
        chk("busy", rd[0], 1);
        for (n = 0; n < 30 && rd[0] !== 1'b0; n = n + 1)
            apb(0, `ARF_BASEBAND_STATUS, 0);
        apb(1, `ARF_MONITOR_RESULT, 32'h3ff);
        apb(0, `ARF_MONITOR_RESULT, 0);
        chk("result", rd, {3'd2, 7'h35});
        apb(0, 12'h0f0, 0);
        chk("slverr", {er, rd[30:0]}, 32'h80000000);
        ulw <= 1'b1;
        for (k = 0; k < 64; k = k + 1)
            apb(1, `ARF_RAMP_MEM_BASE + 12'(4 * k), {5'h0a, 5'h15});
        apb(1, `ARF_RAMP_DELAY, 1);
        for (k = 0; k < 2; k = k + 1) begin
            lvl = ($random(seed) & 32'hff) | 1;
            ofs = $random(seed) & 32'hff;
            apb(1, `ARF_TX_POWER_LEVEL, lvl);
            apb(1, `ARF_POWER_OFFSET, ofs);
            apb(1, `ARF_AUX_CONTROL_TWO, {k[0], k[0], 7'h30});
            ben <= 1'b1;
            for (n = 0; n < 3000 && shc !== 5'h15; n = n + 1) @(posedge pclk);
            chk("level", lvc, lvl);
            chk("drv_up", drv, k ? 21 * lvl + ofs : 21 * (lvl + ofs));
            ben <= 1'b0;
            for (n = 0; n < 3000 && shc !== 5'h0a; n = n + 1) @(posedge pclk);
            chk("drv_dn", drv, k ? 10 * lvl + ofs : 10 * (lvl + ofs));
            for (n = 0; n < 6000 && modl !== 1'b0; n = n + 1) @(posedge pclk);
            // a slow ramp-down outlasts the tail: wait for the sequencer to idle
            do apb(0, `ARF_BASEBAND_STATUS, 0); while (rd[1] !== 1'b0);
            repeat (2) @(posedge pclk);
            chk("drv_off", {shc, drv}, 0);
        end
        results;
    end
endmodule
